// ### tb/tb_top.sv
// self-checking bench for the endpoint flag block
`include "uef_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // event field positions inside the packed event struct
    localparam int P_THR = 11, P_HAS = 10, P_ROOM = 9, P_INTOK = 8, P_TMO = 7;
    localparam int P_IDIS = 6, P_IDONE = 5, P_OTOK = 4, P_SETUP = 3, P_DOK = 2;
    localparam int P_ODIS = 1, P_ODONE = 0;

    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, arready, bvalid, rvalid;
    logic bready = 1'b1, rready = 1'b1;
    logic [1:0] bresp, rresp;
    logic [3:0] irq;
    uef_pkg::uef_event_type ev [4];
    uef_pkg::uef_ctrl_type  ctrl [4];
    int bad_count = 0, samples_checked = 0;

    always #20 aclk = ~aclk;

    uef_top #(.N_EP(4)) u_uef_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ep_event(ev), .ep_ctrl(ctrl), .ep_irq(irq)
    );
    uef_host_model #(.N_EP(4)) u_uef_host_model (.aclk(aclk), .ev(ev));

    // =====
    // bus and compare tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    task automatic wc(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, 4'hf, r);
        chk("write resp", {30'h0, `UEF_RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string n);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, e, d & m);
        chk("read resp", {30'h0, `UEF_RESP_OKAY}, {30'h0, r});
    endtask

    function automatic logic [11:0] ad(input logic [11:0] b, input int e);
        return b + 12'(e * 32);
    endfunction

    task automatic pl(input int e, input int b);
        u_uef_host_model.pulse(e, b);
    endtask

    task automatic lv(input int e, input int b, input logic v);
        u_uef_host_model.level(e, b, v);
    endtask

    // =====
    // scenarios
    task automatic t_reset();
        for (int e = 0; e < 4; e++) begin
            rc(ad(`UEF_IN_FLAGS_OFF, e), '1, 32'h80, "in flags reset");
            rc(ad(`UEF_OUT_FLAGS_OFF, e), '1, 32'h0, "out flags reset");
        end
        chk("irq reset", 32'hf, {28'h0, irq});
        for (int e = 0; e < 4; e++) lv(e, P_THR, 1'b0);
    endtask

    task automatic t_in(input int e);
        logic [11:0] f;
        f = ad(`UEF_IN_FLAGS_OFF, e);
        wc(ad(`UEF_IN_CTRL_OFF, e), 32'h0000_8000);
        lv(e, P_HAS, 1'b1);
        pl(e, P_INTOK);
        rc(f, '1, 32'h0, "token with data");
        lv(e, P_HAS, 1'b0);
        pl(e, P_INTOK);
        rc(f, '1, 32'h10, "underrun");
        pl(e, P_TMO);
        rc(f, '1, 32'h18, "in timeout");
        pl(e, P_IDIS);
        rc(f, '1, 32'h1a, "in disabled");
        pl(e, P_IDONE);
        rc(f, '1, 32'h1b, "in finished");
        chk("irq in set", 32'h1, {31'h0, irq[e]});
        wc(f, 32'hff);
        rc(f, '1, 32'h0, "in clear");
        chk("irq in clear", 32'h0, {31'h0, irq[e]});
        lv(e, P_THR, 1'b1);
        rc(f, '1, 32'h80, "fifo empty set");
        wc(f, 32'h80);
        rc(f, '1, 32'h80, "fifo empty read only");
        lv(e, P_THR, 1'b0);
        rc(f, '1, 32'h0, "fifo empty follows");
    endtask

    task automatic t_nak(input int e);
        logic [11:0] c, f;
        c = ad(`UEF_IN_CTRL_OFF, e);
        f = ad(`UEF_IN_FLAGS_OFF, e);
        wc(c, 32'h0800_8000);
        rc(c, 32'h0002_8000, 32'h0002_8000, "nak status");
        chk("nak out", 32'h1, {31'h0, ctrl[e].in_nak});
        rc(f, '1, 32'h40, "nak effective");
        wc(c, 32'h0400_8000);
        rc(f, '1, 32'h0, "nak cleared");
        rc(c, 32'h0002_8000, 32'h0000_8000, "nak status off");
        wc(c, 32'h0800_8000);
        wc(f, 32'h40);
        rc(f, '1, 32'h0, "nak write one clear");
        wc(c, 32'h0400_8000);
    endtask

    task automatic t_out();
        logic [11:0] c, f;
        logic [1:0] r;
        c = `UEF_OUT_CTRL_OFF;
        f = `UEF_OUT_FLAGS_OFF;
        wc(c, 32'h2000_87ff);
        rc(c, 32'h0001_87ff, 32'h0001_87ff, "ctrl max len toggle");
        chk("max len out", 32'h7ff, {21'h0, ctrl[0].max_packet_length});
        pl(0, P_DOK);
        rc(c, 32'h0001_0000, 32'h0, "toggle flip");
        pl(0, P_DOK);
        rc(c, 32'h0001_0000, 32'h0001_0000, "toggle flip back");
        wc(c, 32'h1000_87ff);
        rc(c, 32'h0001_0000, 32'h0, "set data0");
        chk("toggle out", 32'h0, {31'h0, ctrl[0].data_toggle_bit});
        for (int i = 0; i < 3; i++) pl(0, P_SETUP);
        rc(f, '1, 32'h0, "three setups");
        pl(0, P_SETUP);
        rc(f, '1, 32'h40, "fourth setup");
        pl(0, P_OTOK);
        rc(f, '1, 32'h48, "setup done");
        lv(0, P_ROOM, 1'b0);
        pl(0, P_OTOK);
        rc(f, '1, 32'h58, "overrun");
        lv(0, P_ROOM, 1'b1);
        pl(0, P_ODONE);
        pl(0, P_ODIS);
        rc(f, '1, 32'h5b, "out finished disabled");
        wr(f, 32'h5b, 4'h3, r);
        chk("partial resp", {30'h0, `UEF_RESP_SLVERR}, {30'h0, r});
        rc(f, '1, 32'h5b, "partial no effect");
        wc(f, 32'h5b);
        rc(f, '1, 32'h0, "out clear");
        // event and write-one clear land on the same edge: the set must win
        fork
            wc(f, 32'h1);
            pl(0, P_ODONE);
        join
        rc(f, '1, 32'h1, "set beats clear");
    endtask

    task automatic t_idle();
        logic [31:0] d;
        logic [1:0] r;
        pl(2, P_SETUP);
        pl(2, P_OTOK);
        pl(2, P_INTOK);
        rc(ad(`UEF_OUT_FLAGS_OFF, 2), '1, 32'h0, "inactive out");
        rc(ad(`UEF_IN_FLAGS_OFF, 2), '1, 32'h0, "inactive in");
        rd(12'h004, d, r);
        chk("unmapped data", 32'h0, d);
        chk("unmapped resp", {30'h0, `UEF_RESP_SLVERR}, {30'h0, r});
    endtask

    // =====
    // run control
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_in(0);
        t_in(1);
        t_nak(0);
        t_nak(3);
        t_out();
        t_idle();
        end_sim();
    end
endmodule

// ### tb/uef_host_model.sv
// usb host side model: drives per-endpoint token, event and fifo level inputs
module uef_host_model #(
    parameter int N_EP = 4
) (
    input  wire logic              aclk,
    output uef_pkg::uef_event_type ev [N_EP]
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====
    // event drive
    initial begin
        for (int e = 0; e < N_EP; e++) begin
            ev[e] = '0;
            ev[e].tx_at_threshold = 1'b1;
            ev[e].rx_room = 1'b1;
        end
    end

    // fifo levels change just after an edge and then stand
    // one more edge: a level-driven flag needs a cycle before it reads back
    task automatic level(input int e, input int b, input logic v);
        @(posedge aclk);
        ev[e][b] <= v;
        @(posedge aclk);
    endtask

    // a token or event is seen once, so it lasts exactly one cycle
    task automatic pulse(input int e, input int b);
        @(posedge aclk);
        ev[e][b] <= 1'b1;
        @(posedge aclk);
        ev[e][b] <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

// ### verilog/uef_map.svh
// register offsets, field positions and reset values of the endpoint flag block
`ifndef UEF_MAP_SVH
`define UEF_MAP_SVH
`define UEF_IN_CTRL_OFF   12'h900
`define UEF_IN_FLAGS_OFF  12'h908
`define UEF_OUT_CTRL_OFF  12'hb00
`define UEF_OUT_FLAGS_OFF 12'hb08
`define UEF_TX_FIFO_EMPTY_FLAG_BIT      7
`define UEF_INNAK_BIT     6
`define UEF_UNDR_BIT      4
`define UEF_CONTROL_IN_TIMEOUT_FLAG_BIT      3
`define UEF_DIS_BIT       1
`define UEF_TF_BIT        0
`define UEF_BURST_BIT     6
`define UEF_OVR_BIT       4
`define UEF_STP_BIT       3
`define UEF_SD1_BIT       29
`define UEF_SD0_BIT       28
`define UEF_SET_NAK_REQUEST_BIT      27
`define UEF_CLEAR_NAK_REQUEST_BIT      26
`define UEF_NAK_STATUS_BIT      17
`define UEF_TOG_BIT       16
`define UEF_ACT_BIT       15
`define UEF_IN_FLAGS_RST  8'h80
`define UEF_OUT_FLAGS_RST 7'h00
`define UEF_IN_W1C_MASK   8'h5b
`define UEF_OUT_W1C_MASK  7'h5b
`define UEF_SETUP_LIMIT   3'h3
`define UEF_RESP_OKAY     2'b00
`define UEF_RESP_SLVERR   2'b10
`endif

// ### verilog/uef_pkg.sv
// types shared by the endpoint flag block
package uef_pkg;
    typedef enum logic [1:0] {
        UEF_IN_CTRL,
        UEF_IN_FLAGS,
        UEF_OUT_CTRL,
        UEF_OUT_FLAGS
    } uef_kind_type;

    // per-endpoint events from the packet engine, same clock, one-cycle pulses
    // except the three fifo levels
    typedef struct packed {
        logic tx_at_threshold;
        logic tx_has_data;
        logic rx_room;
        logic in_token;
        logic ctrl_in_timeout;
        logic in_disabled;
        logic in_done;
        logic out_token;
        logic setup_token;
        logic out_data_ok;
        logic out_disabled;
        logic out_done;
    } uef_event_type;

    // per-endpoint controls back to the packet engine
    typedef struct packed {
        logic        in_active;
        logic        out_active;
        logic        in_nak;
        logic        out_nak;
        logic        overrun_nak;
        logic        data_toggle_bit;
        logic [10:0] max_packet_length;
    } uef_ctrl_type;
endpackage

// ### verilog/uef_top.sv
// endpoint control words and in/out event flag registers behind axi4-lite
`include "uef_map.svh"

// Behaviour
// - inactive endpoint ignores all tokens, no answer
// - out ctrl bits 10:0 hold maximum packet length
// - in flags write-one-clear, fifo empty read-only
// - in bit 7 tracks tx fifo threshold
// - in bit 6 on nak effect, clear nak clears
// - in bit 4 on token with empty fifo
// - in bit 3 on control in timeout
// - bit 1 when endpoint disabled on request
// - in bit 0 when in transfer finished
// - out bit 0 when out transfer finished
// - out flags write-one-clear, full word only
// - out bit 6 after over three setups
// - no rx room: drop, nak, bit 4
// - out bit 3 on token after setup
// - reset values 0x80 in, zero out
// - set-data0 write clears the toggle
// - set-nak write sets nak status
module uef_top #(
    parameter int N_EP = 4
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire uef_pkg::uef_event_type ep_event [N_EP],
    output uef_pkg::uef_ctrl_type      ep_ctrl [N_EP],
    output logic [N_EP-1:0]            ep_irq
);
    // ========================================================
    // address decode
    function automatic logic [4:0] decode(input logic [11:0] a);
        logic [11:0] base;
        logic [4:0]  r;
        base = {a[11:7], 2'b00, a[4:0]};
        r = {1'b0, 2'b00, a[6:5]};
        if (base == `UEF_IN_CTRL_OFF) r = {1'b1, uef_pkg::UEF_IN_CTRL, a[6:5]};
        if (base == `UEF_IN_FLAGS_OFF) r = {1'b1, uef_pkg::UEF_IN_FLAGS, a[6:5]};
        if (base == `UEF_OUT_CTRL_OFF) r = {1'b1, uef_pkg::UEF_OUT_CTRL, a[6:5]};
        if (base == `UEF_OUT_FLAGS_OFF) r = {1'b1, uef_pkg::UEF_OUT_FLAGS, a[6:5]};
        return r;
    endfunction

    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [4:0]  wdec;
    logic        wr_fire;
    logic        wr_ok;
    logic [N_EP-1:0] wr_in_ctrl, wr_in_flags, wr_out_ctrl, wr_out_flags;

    assign wdec    = decode(awaddr_q);
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    // partial-word writes are refused: flags must not be half-cleared
    assign wr_ok   = wr_fire && wdec[4] && (wstrb_q == 4'hf);

    always_comb begin
        for (int e = 0; e < N_EP; e++) begin
            wr_in_ctrl[e]   = wr_ok && wdec[1:0] == e[1:0]
                              && wdec[3:2] == uef_pkg::UEF_IN_CTRL;
            wr_in_flags[e]  = wr_ok && wdec[1:0] == e[1:0]
                              && wdec[3:2] == uef_pkg::UEF_IN_FLAGS;
            wr_out_ctrl[e]  = wr_ok && wdec[1:0] == e[1:0]
                              && wdec[3:2] == uef_pkg::UEF_OUT_CTRL;
            wr_out_flags[e] = wr_ok && wdec[1:0] == e[1:0]
                              && wdec[3:2] == uef_pkg::UEF_OUT_FLAGS;
        end
    end

    // ========================================================
    // axi write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `UEF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_hold_q     <= 1'b0;
                w_hold_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ========================================================
    // endpoint state
    logic [7:0]  in_flags_q  [N_EP];
    logic [6:0]  out_flags_q [N_EP];
    logic [2:0]  setup_cnt_q [N_EP];
    logic [N_EP-1:0] setup_seen_q, in_nak_prev_q;

    always_ff @(posedge aclk) begin
        for (int e = 0; e < N_EP; e++) begin
            if (!aresetn) begin
                ep_ctrl[e] <= '0;
            end else begin
                ep_ctrl[e].overrun_nak <= ep_ctrl[e].out_active && ep_event[e].out_token
                                          && !ep_event[e].rx_room;
                if (ep_ctrl[e].out_active && ep_event[e].out_data_ok)
                    ep_ctrl[e].data_toggle_bit <= !ep_ctrl[e].data_toggle_bit;
                if (wr_in_ctrl[e]) begin
                    ep_ctrl[e].in_active <= wdata_q[`UEF_ACT_BIT];
                    if (wdata_q[`UEF_SET_NAK_REQUEST_BIT])
                        ep_ctrl[e].in_nak <= 1'b1;
                    else if (wdata_q[`UEF_CLEAR_NAK_REQUEST_BIT])
                        ep_ctrl[e].in_nak <= 1'b0;
                end
                if (wr_out_ctrl[e]) begin
                    ep_ctrl[e].out_active        <= wdata_q[`UEF_ACT_BIT];
                    ep_ctrl[e].max_packet_length <= wdata_q[10:0];
                    if (wdata_q[`UEF_SET_NAK_REQUEST_BIT])
                        ep_ctrl[e].out_nak <= 1'b1;
                    else if (wdata_q[`UEF_CLEAR_NAK_REQUEST_BIT])
                        ep_ctrl[e].out_nak <= 1'b0;
                    if (wdata_q[`UEF_SD0_BIT])
                        ep_ctrl[e].data_toggle_bit <= 1'b0;
                    else if (wdata_q[`UEF_SD1_BIT])
                        ep_ctrl[e].data_toggle_bit <= 1'b1;
                end
            end
        end
    end

    // in flags: hardware set wins over a same-cycle write-one clear
    always_ff @(posedge aclk) begin
        for (int e = 0; e < N_EP; e++) begin
            if (!aresetn) begin
                in_flags_q[e]    <= `UEF_IN_FLAGS_RST;
                in_nak_prev_q[e] <= 1'b0;
            end else begin
                logic [7:0] set;
                logic [7:0] clr;
                set = 8'h00;
                clr = wr_in_flags[e] ? (wdata_q[7:0] & `UEF_IN_W1C_MASK) : 8'h00;
                if (wr_in_ctrl[e] && wdata_q[`UEF_CLEAR_NAK_REQUEST_BIT])
                    clr[`UEF_INNAK_BIT] = 1'b1;
                set[`UEF_INNAK_BIT] = ep_ctrl[e].in_nak && !in_nak_prev_q[e];
                set[`UEF_UNDR_BIT]  = ep_ctrl[e].in_active && ep_event[e].in_token
                                      && !ep_event[e].tx_has_data;
                set[`UEF_CONTROL_IN_TIMEOUT_FLAG_BIT]  = ep_event[e].ctrl_in_timeout;
                set[`UEF_DIS_BIT]   = ep_event[e].in_disabled;
                set[`UEF_TF_BIT]    = ep_event[e].in_done;
                in_flags_q[e] <= (in_flags_q[e] & ~clr) | set;
                in_flags_q[e][`UEF_TX_FIFO_EMPTY_FLAG_BIT] <= ep_event[e].tx_at_threshold;
                in_nak_prev_q[e] <= ep_ctrl[e].in_nak;
            end
        end
    end

    // out flags and setup tracking
    always_ff @(posedge aclk) begin
        for (int e = 0; e < N_EP; e++) begin
            if (!aresetn) begin
                out_flags_q[e]  <= `UEF_OUT_FLAGS_RST;
                setup_cnt_q[e]  <= 3'h0;
                setup_seen_q[e] <= 1'b0;
            end else begin
                logic [6:0] set;
                logic [6:0] clr;
                logic       tok;
                set = 7'h00;
                clr = wr_out_flags[e] ? (wdata_q[6:0] & `UEF_OUT_W1C_MASK) : 7'h00;
                tok = ep_ctrl[e].out_active && ep_event[e].out_token
                      || ep_ctrl[e].in_active && ep_event[e].in_token;
                if (ep_ctrl[e].out_active && ep_event[e].setup_token) begin
                    setup_seen_q[e] <= 1'b1;
                    if (setup_cnt_q[e] == `UEF_SETUP_LIMIT)
                        set[`UEF_BURST_BIT] = 1'b1;
                    else
                        setup_cnt_q[e] <= setup_cnt_q[e] + 3'h1;
                end else if (tok) begin
                    setup_cnt_q[e]  <= 3'h0;
                    setup_seen_q[e] <= 1'b0;
                    set[`UEF_STP_BIT] = setup_seen_q[e];
                end
                set[`UEF_OVR_BIT] = ep_ctrl[e].out_active && ep_event[e].out_token
                                    && !ep_event[e].rx_room;
                set[`UEF_DIS_BIT] = ep_event[e].out_disabled;
                set[`UEF_TF_BIT]  = ep_event[e].out_done;
                out_flags_q[e] <= (out_flags_q[e] & ~clr) | set;
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int e = 0; e < N_EP; e++) begin
            if (!aresetn)
                ep_irq[e] <= 1'b0;
            else
                ep_irq[e] <= (|in_flags_q[e]) || (|out_flags_q[e]);
        end
    end

    // ========================================================
    // axi read channel
    function automatic logic [31:0] rd_word(input logic [4:0] d);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (uef_pkg::uef_kind_type'(d[3:2]))
            uef_pkg::UEF_IN_CTRL: begin
                v[`UEF_ACT_BIT]  = ep_ctrl[d[1:0]].in_active;
                v[`UEF_NAK_STATUS_BIT] = ep_ctrl[d[1:0]].in_nak;
            end
            uef_pkg::UEF_IN_FLAGS:  v[7:0] = in_flags_q[d[1:0]];
            uef_pkg::UEF_OUT_CTRL: begin
                v[10:0]          = ep_ctrl[d[1:0]].max_packet_length;
                v[`UEF_ACT_BIT]  = ep_ctrl[d[1:0]].out_active;
                v[`UEF_TOG_BIT]  = ep_ctrl[d[1:0]].data_toggle_bit;
                v[`UEF_NAK_STATUS_BIT] = ep_ctrl[d[1:0]].out_nak;
            end
            uef_pkg::UEF_OUT_FLAGS: v[6:0] = out_flags_q[d[1:0]];
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    logic [4:0] rdec;
    assign rdec = decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `UEF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdec[4] ? rd_word(rdec) : 32'h0000_0000;
            s_axi_rresp   <= rdec[4] ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ========================================================
    // assertions on endpoint 0 and on the write response
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_set_nak_request_wr;
        wr_in_ctrl[0] && wdata_q[`UEF_SET_NAK_REQUEST_BIT] && !ep_ctrl[0].in_nak;
    endsequence
    sequence s_nak_flag;
        ep_ctrl[0].in_nak ##1 in_flags_q[0][`UEF_INNAK_BIT];
    endsequence

    property p_nak_effect;
        s_set_nak_request_wr |=> s_nak_flag;
    endproperty
    a_nak_effect: assert property (p_nak_effect) else $error("nak effect flag late");
    property p_underrun;
        ep_ctrl[0].in_active && ep_event[0].in_token && !ep_event[0].tx_has_data
            |=> in_flags_q[0][`UEF_UNDR_BIT];
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not flagged");
    property p_inactive;
        $rose(in_flags_q[0][`UEF_UNDR_BIT]) |-> $past(ep_ctrl[0].in_active);
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive endpoint answered");
    property p_overrun;
        ep_ctrl[0].out_active && ep_event[0].out_token && !ep_event[0].rx_room
            |=> out_flags_q[0][`UEF_OVR_BIT] && ep_ctrl[0].overrun_nak;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");
    property p_tx_fifo_empty_flag;
        in_flags_q[0][`UEF_TX_FIFO_EMPTY_FLAG_BIT] == $past(ep_event[0].tx_at_threshold);
    endproperty
    a_tx_fifo_empty_flag: assert property (p_tx_fifo_empty_flag) else $error("fifo empty flag wrong");
    property p_set_wins;
        ep_event[0].out_done && wr_out_flags[0] && wdata_q[`UEF_TF_BIT]
            |=> out_flags_q[0][`UEF_TF_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");
    property p_data0;
        wr_out_ctrl[0] && wdata_q[`UEF_SD0_BIT] && !(ep_ctrl[0].out_active
            && ep_event[0].out_data_ok) |=> !ep_ctrl[0].data_toggle_bit;
    endproperty
    a_data0: assert property (p_data0) else $error("toggle not cleared");
    property p_irq;
        (|in_flags_q[0]) || (|out_flags_q[0]) |=> ep_irq[0];
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
    property p_reset;
        $past(!aresetn) |-> in_flags_q[0] == `UEF_IN_FLAGS_RST
            && out_flags_q[0] == `UEF_OUT_FLAGS_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset value");
    property p_partial;
        wr_fire && wstrb_q != 4'hf |=> s_axi_bresp == `UEF_RESP_SLVERR;
    endproperty
    a_partial: assert property (p_partial) else $error("partial write taken");
endmodule
